// ### pkg/rmsq_defines.vh
`ifndef RMSQ_DEFINES_VH
`define RMSQ_DEFINES_VH
// Register indices on the plain register port
`define RMSQ_ADDR_CFG1 8'h00
`define RMSQ_ADDR_CFG2 8'h01
`define RMSQ_ADDR_TMR1 8'h02
`define RMSQ_ADDR_TMR2 8'h03
`define RMSQ_ADDR_STAT 8'h04
// Config one field positions
`define RMSQ_C1_LAUNCH 7
`define RMSQ_C1_HALT 6
`define RMSQ_C1_IDLE_PWR 5
`define RMSQ_C1_START_HI 4
`define RMSQ_C1_START_LO 3
`define RMSQ_C1_LOW_PWR 2
`define RMSQ_C1_IDLE_EXIT 1
`define RMSQ_C1_TX_EXIT 0
// Config two field positions
`define RMSQ_C2_RX_HI 7
`define RMSQ_C2_RX_LO 5
`define RMSQ_C2_TO_HI 4
`define RMSQ_C2_TO_LO 3
`define RMSQ_C2_PD_HI 2
`define RMSQ_C2_PD_LO 0
// Timer register fields: step in [9:8], multiplier in [7:0]
`define RMSQ_T_STEP_HI 9
`define RMSQ_T_STEP_LO 8
`define RMSQ_T_MULT_HI 7
`define RMSQ_T_MULT_LO 0
// Reset values
`define RMSQ_CFG1_RST 8'h00
`define RMSQ_CFG2_RST 8'h00
`define RMSQ_TMR_RST 10'h000
// Chip mode codes
`define RMSQ_MODE_SLEEP 3'h0
`define RMSQ_MODE_STBY 3'h1
`define RMSQ_MODE_SYNTH 3'h2
`define RMSQ_MODE_TX 3'h3
`define RMSQ_MODE_RX 3'h4
// Start exit codes
`define RMSQ_SX_LPSEL 2'h0
`define RMSQ_SX_RX 2'h1
`define RMSQ_SX_TX 2'h2
`define RMSQ_SX_TX_LVL 2'h3
// Receive exit codes
`define RMSQ_RX_PLD_PKT 3'h1
`define RMSQ_RX_PLD_LP 3'h2
`define RMSQ_RX_CRC_PKT 3'h3
`define RMSQ_RX_LVL_OFF 3'h4
`define RMSQ_RX_SYNC_OFF 3'h5
`define RMSQ_RX_PRE_OFF 3'h6
// Timeout exit codes
`define RMSQ_TO_RESTART 2'h0
`define RMSQ_TO_TX 2'h1
`define RMSQ_TO_LPSEL 2'h2
`define RMSQ_TO_OFF 2'h3
// Packet-done exit codes
`define RMSQ_PD_OFF 3'h0
`define RMSQ_PD_TX_EMPTY 3'h1
`define RMSQ_PD_LPSEL 3'h2
`define RMSQ_PD_RX_SYNTH 3'h3
`define RMSQ_PD_RX 3'h4
// Timer step codes
`define RMSQ_STEP_OFF 2'h0
`define RMSQ_STEP_SHORT 2'h1
`define RMSQ_STEP_MID 2'h2
`define RMSQ_STEP_LONG 2'h3
// Timer steps, in ns, and clock period in ns
`define RMSQ_CLK_NS 5
`define RMSQ_STEP_SHORT_NS 64000
`define RMSQ_STEP_MID_NS 4100000
`define RMSQ_STEP_LONG_NS 262000000
`endif

// ### verilog/rmsq_step_timer.v
`include "rmsq_defines.vh"
// One sequencer timer: step size times multiplier, counted in clock cycles
module rmsq_step_timer #(
  parameter [27:0] SHORT_CYC = 28'h0003200,
  parameter [27:0] MID_CYC = 28'h00C8320,
  parameter [27:0] LONG_CYC = 28'h31F7E60
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire arm_i,
  input wire stop_i,
  input wire [1:0] step_i,
  input wire [7:0] mult_i,
  output wire fire_o,
  output wire running_o
);
  reg [27:0] tick_reg;
  reg [7:0] mult_cnt_reg;
  reg run_reg;
  reg [27:0] step_cyc;
  wire step_end;
  wire last_step;

  // Decode step size; disabled or zero multiplier never fires
  always @* begin
    case (step_i)
      `RMSQ_STEP_SHORT: step_cyc = SHORT_CYC;
      `RMSQ_STEP_MID: step_cyc = MID_CYC;
      `RMSQ_STEP_LONG: step_cyc = LONG_CYC;
      default: step_cyc = 28'h0000000;
    endcase
  end

  assign step_end = run_reg && (tick_reg + 28'h0000001 >= step_cyc);
  assign last_step = (mult_cnt_reg + 8'h01 >= mult_i);
  assign fire_o = step_end && last_step;
  assign running_o = run_reg;

  // Count steps; arming restarts the interval from zero
  always @(posedge sys_clk_i) begin
    if (rst_i || stop_i) begin
      run_reg <= 1'b0;
      tick_reg <= 28'h0000000;
      mult_cnt_reg <= 8'h00;
    end else if (arm_i) begin
      run_reg <= (step_i != `RMSQ_STEP_OFF) && (mult_i != 8'h00);
      tick_reg <= 28'h0000000;
      mult_cnt_reg <= 8'h00;
    end else if (step_end) begin
      tick_reg <= 28'h0000000;
      mult_cnt_reg <= last_step ? 8'h00 : mult_cnt_reg + 8'h01;
      run_reg <= !last_step;
    end else if (run_reg) begin
      tick_reg <= tick_reg + 28'h0000001;
    end
  end
endmodule // rmsq_step_timer

// ### verilog/rmsq_sequencer.v
// Contract
// - Launch only from Sleep or Standby
// - Halt forces off from any state
// - Acts only in FSK/OOK modulation
// - Off via low-power selection restores initial mode
// - Idle holds Standby or Sleep per bit
// - Idle exits on timer one only
// - Packet-received keeps receiver on
// - Start exit select picks first state
// - Low-power choice picks off or idle
// - Record initial mode at launch
// - Transmit exits on frame sent
// - Receive exit code picks event and target
// - Bad check with code 011 means timeout
// - Timer two leaves receive always
// - Timeout exit select picks next state
// - Three wait timeouts raise receive timeout
// - Packet-done exit select picks next state
// - Timers alternate after launch
// - Step code decodes timer resolution
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "rmsq_defines.vh"
module rmsq_sequencer (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire fsk_mode_i,
  input wire [2:0] chip_mode_i,
  input wire crc_enable_i,
  input wire bad_check_auto_flush_i,
  input wire frame_sent_event_i,
  input wire payload_ready_event_i,
  input wire check_good_event_i,
  input wire level_event_i,
  input wire sync_match_event_i,
  input wire preamble_seen_event_i,
  input wire queue_level_event_i,
  input wire queue_drained_event_i,
  input wire level_wait_timeout_i,
  input wire preamble_wait_timeout_i,
  input wire sync_wait_timeout_i,
  output reg [2:0] mode_cmd_o,
  output reg mode_cmd_valid_o,
  output reg receiver_relaunch_o,
  output wire timer_one_event_o,
  output wire timer_two_event_o,
  output wire [2:0] seq_state_o
);
  // Cycle counts for the timer steps (shortest is well over 4096 cycles)
  localparam [31:0] SHORT_CYC_W = `RMSQ_STEP_SHORT_NS / `RMSQ_CLK_NS;
  localparam [31:0] MID_CYC_W = `RMSQ_STEP_MID_NS / `RMSQ_CLK_NS;
  localparam [31:0] LONG_CYC_W = `RMSQ_STEP_LONG_NS / `RMSQ_CLK_NS;
  // All three fit in 28 bits, so the top bits are cut on purpose
  localparam [27:0] SHORT_CYC = SHORT_CYC_W[27:0];
  localparam [27:0] MID_CYC = MID_CYC_W[27:0];
  localparam [27:0] LONG_CYC = LONG_CYC_W[27:0];

  // Sequencer states
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_TX = 3'h2;
  localparam [2:0] ST_RX = 3'h3;
  localparam [2:0] ST_PKT = 3'h4;
  localparam [2:0] ST_LPSEL = 3'h5;
  localparam [2:0] ST_TIMEOUT = 3'h6;
  localparam [2:0] ST_WAIT_LVL = 3'h7;

  reg [7:0] cfg1_reg;
  reg [7:0] cfg2_reg;
  reg [9:0] tmr1_reg;
  reg [9:0] tmr2_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg init_sleep_reg;
  reg synth_hop_reg;
  reg synth_hop_next;
  reg relaunch_next;
  reg [2:0] mode_next;
  reg mode_valid_next;
  reg armed_launch;
  wire launch_cmd;
  wire halt_cmd;
  wire rx_timeout;
  wire t1_fire;
  wire t2_fire;
  wire t1_arm;
  wire t2_arm;
  wire low_power_now;
  wire [1:0] start_sel;
  wire [2:0] rx_sel;
  wire [1:0] to_sel;
  wire [2:0] pd_sel;
  wire [2:0] idle_mode;
  wire [2:0] init_mode;

  // Launch and halt are write-one command bits, never stored
  assign launch_cmd = reg_wr_i && (reg_addr_i == `RMSQ_ADDR_CFG1) &&
                      reg_wdata_i[`RMSQ_C1_LAUNCH];
  assign halt_cmd = reg_wr_i && (reg_addr_i == `RMSQ_ADDR_CFG1) &&
                    reg_wdata_i[`RMSQ_C1_HALT];
  assign low_power_now = (chip_mode_i == `RMSQ_MODE_SLEEP) ||
                         (chip_mode_i == `RMSQ_MODE_STBY);
  // Start exit rides in the launch write itself; the stored copy is a cycle late
  assign start_sel = reg_wdata_i[`RMSQ_C1_START_HI:`RMSQ_C1_START_LO];
  assign rx_sel = cfg2_reg[`RMSQ_C2_RX_HI:`RMSQ_C2_RX_LO];
  assign to_sel = cfg2_reg[`RMSQ_C2_TO_HI:`RMSQ_C2_TO_LO];
  assign pd_sel = cfg2_reg[`RMSQ_C2_PD_HI:`RMSQ_C2_PD_LO];
  assign idle_mode = cfg1_reg[`RMSQ_C1_IDLE_PWR] ? `RMSQ_MODE_SLEEP
                                                 : `RMSQ_MODE_STBY;
  assign init_mode = init_sleep_reg ? `RMSQ_MODE_SLEEP : `RMSQ_MODE_STBY;
  assign rx_timeout = level_wait_timeout_i || preamble_wait_timeout_i ||
                      sync_wait_timeout_i;

  // Launch is honoured only from a low-power mode in FSK/OOK
  always @* begin
    armed_launch = launch_cmd && !halt_cmd && low_power_now && fsk_mode_i;
  end

  // Timer one restarts on launch or timer two; timer two on timer one
  assign t1_arm = armed_launch || t2_fire;
  assign t2_arm = t1_fire;
  assign timer_one_event_o = t1_fire;
  assign timer_two_event_o = t2_fire;
  assign seq_state_o = state_reg;

  // The timers run on their own, whatever state the sequencer is in
  rmsq_step_timer #(
    .SHORT_CYC(SHORT_CYC),
    .MID_CYC(MID_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer_one (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .arm_i(t1_arm),
    .stop_i(halt_cmd || !fsk_mode_i),
    .step_i(tmr1_reg[`RMSQ_T_STEP_HI:`RMSQ_T_STEP_LO]),
    .mult_i(tmr1_reg[`RMSQ_T_MULT_HI:`RMSQ_T_MULT_LO]),
    .fire_o(t1_fire),
    .running_o()
  );

  rmsq_step_timer #(
    .SHORT_CYC(SHORT_CYC),
    .MID_CYC(MID_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer_two (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .arm_i(t2_arm),
    .stop_i(halt_cmd || !fsk_mode_i),
    .step_i(tmr2_reg[`RMSQ_T_STEP_HI:`RMSQ_T_STEP_LO]),
    .mult_i(tmr2_reg[`RMSQ_T_MULT_HI:`RMSQ_T_MULT_LO]),
    .fire_o(t2_fire),
    .running_o()
  );

  // Register writes; command bits are not kept in config one
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg1_reg <= `RMSQ_CFG1_RST;
      cfg2_reg <= `RMSQ_CFG2_RST;
      tmr1_reg <= `RMSQ_TMR_RST;
      tmr2_reg <= `RMSQ_TMR_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `RMSQ_ADDR_CFG1: begin
          cfg1_reg <= {2'h0, reg_wdata_i[`RMSQ_C1_IDLE_PWR:`RMSQ_C1_TX_EXIT]};
        end
        `RMSQ_ADDR_CFG2: begin
          cfg2_reg <= reg_wdata_i[`RMSQ_C2_RX_HI:`RMSQ_C2_PD_LO];
        end
        `RMSQ_ADDR_TMR1: begin
          tmr1_reg <= reg_wdata_i[`RMSQ_T_STEP_HI:`RMSQ_T_MULT_LO];
        end
        `RMSQ_ADDR_TMR2: begin
          tmr2_reg <= reg_wdata_i[`RMSQ_T_STEP_HI:`RMSQ_T_MULT_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `RMSQ_ADDR_CFG1: reg_rdata_o <= {8'h00, cfg1_reg};
        `RMSQ_ADDR_CFG2: reg_rdata_o <= {8'h00, cfg2_reg};
        `RMSQ_ADDR_TMR1: reg_rdata_o <= {6'h00, tmr1_reg};
        `RMSQ_ADDR_TMR2: reg_rdata_o <= {6'h00, tmr2_reg};
        `RMSQ_ADDR_STAT: reg_rdata_o <= {11'h000, init_sleep_reg, 1'b0, state_reg};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // Next state and mode request; halt outranks every other cause
  always @* begin
    state_next = state_reg;
    mode_next = mode_cmd_o;
    mode_valid_next = 1'b0;
    relaunch_next = 1'b0;
    synth_hop_next = 1'b0;
    if (halt_cmd || !fsk_mode_i) begin
      state_next = ST_OFF;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (armed_launch) begin
            case (start_sel)
              `RMSQ_SX_LPSEL: state_next = ST_LPSEL;
              `RMSQ_SX_RX: state_next = ST_RX;
              `RMSQ_SX_TX: state_next = ST_TX;
              default: state_next = ST_WAIT_LVL;
            endcase
          end
        end
        ST_WAIT_LVL: begin
          if (queue_level_event_i) begin
            state_next = ST_TX;
          end
        end
        ST_LPSEL: begin
          if (cfg1_reg[`RMSQ_C1_LOW_PWR]) begin
            state_next = ST_IDLE;
            mode_next = idle_mode;
          end else begin
            state_next = ST_OFF;
            mode_next = init_mode;
          end
          mode_valid_next = 1'b1;
        end
        ST_IDLE: begin
          if (t1_fire) begin
            state_next = cfg1_reg[`RMSQ_C1_IDLE_EXIT] ? ST_RX : ST_TX;
          end
        end
        ST_TX: begin
          if (frame_sent_event_i) begin
            state_next = cfg1_reg[`RMSQ_C1_TX_EXIT] ? ST_RX : ST_LPSEL;
          end
        end
        ST_RX: begin
          if (t2_fire) begin
            state_next = ST_LPSEL;
          end else if (rx_timeout) begin
            state_next = ST_TIMEOUT;
          end else begin
            case (rx_sel)
              `RMSQ_RX_PLD_PKT: if (payload_ready_event_i) state_next = ST_PKT;
              `RMSQ_RX_PLD_LP: if (payload_ready_event_i) state_next = ST_LPSEL;
              `RMSQ_RX_CRC_PKT: begin
                if (check_good_event_i) begin
                  state_next = ST_PKT;
                end else if (payload_ready_event_i && crc_enable_i &&
                             !bad_check_auto_flush_i) begin
                  state_next = ST_TIMEOUT;
                end
              end
              `RMSQ_RX_LVL_OFF: if (level_event_i) state_next = ST_OFF;
              `RMSQ_RX_SYNC_OFF: if (sync_match_event_i) state_next = ST_OFF;
              `RMSQ_RX_PRE_OFF: if (preamble_seen_event_i) state_next = ST_OFF;
              default: state_next = ST_RX;
            endcase
          end
        end
        ST_TIMEOUT: begin
          case (to_sel)
            `RMSQ_TO_RESTART: begin
              state_next = ST_RX;
              relaunch_next = 1'b1;
            end
            `RMSQ_TO_TX: state_next = ST_TX;
            `RMSQ_TO_LPSEL: state_next = ST_LPSEL;
            default: state_next = ST_OFF;
          endcase
        end
        ST_PKT: begin
          case (pd_sel)
            `RMSQ_PD_OFF: state_next = ST_OFF;
            `RMSQ_PD_TX_EMPTY: if (queue_drained_event_i) state_next = ST_TX;
            `RMSQ_PD_LPSEL: state_next = ST_LPSEL;
            `RMSQ_PD_RX_SYNTH: begin
              state_next = ST_RX;
              synth_hop_next = 1'b1;
            end
            `RMSQ_PD_RX: state_next = ST_RX;
            default: state_next = ST_PKT;
          endcase
        end
        default: state_next = ST_OFF;
      endcase
    end
    // Active states command their chip mode on entry
    if (state_next != state_reg) begin
      if (state_next == ST_TX) begin
        mode_next = `RMSQ_MODE_TX;
        mode_valid_next = 1'b1;
      end else if (state_next == ST_RX) begin
        mode_next = synth_hop_next ? `RMSQ_MODE_SYNTH : `RMSQ_MODE_RX;
        mode_valid_next = 1'b1;
      end
    end
    // Synth hop finishes in receive mode on the next cycle
    if (synth_hop_reg && state_reg == ST_RX && state_next == ST_RX) begin
      mode_next = `RMSQ_MODE_RX;
      mode_valid_next = 1'b1;
    end
  end

  // State, initial mode and mode command registers
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_OFF;
      init_sleep_reg <= 1'b0;
      synth_hop_reg <= 1'b0;
      mode_cmd_o <= `RMSQ_MODE_STBY;
      mode_cmd_valid_o <= 1'b0;
      receiver_relaunch_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      synth_hop_reg <= synth_hop_next;
      mode_cmd_o <= mode_next;
      mode_cmd_valid_o <= mode_valid_next;
      receiver_relaunch_o <= relaunch_next;
      if (armed_launch && state_reg == ST_OFF) begin
        init_sleep_reg <= (chip_mode_i == `RMSQ_MODE_SLEEP);
      end
    end
  end
  // Packet-received issues no command, so the receiver stays on
endmodule // rmsq_sequencer

// ### verification/rmsq_sequencer_sva.sv
module rmsq_sequencer_sva (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire fsk_mode_i,
  input wire frame_sent_event_i,
  input wire [2:0] mode_cmd_o,
  input wire receiver_relaunch_o,
  input wire timer_one_event_o,
  input wire timer_two_event_o,
  input wire [2:0] seq_state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  reg [5:0] cfg_reg;
  wire quiet = fsk_mode_i && !reg_wr_i;
  wire halt_wr = reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[6] && !reg_wdata_i[7];
  // Shadow of the low config bits, so the idle, transmit and low-power exits can be predicted
  always @(posedge sys_clk_i) begin
    if (rst_i) cfg_reg <= 6'h00;
    else if (reg_wr_i && reg_addr_i == 8'h00) cfg_reg <= reg_wdata_i[5:0];
  end
  property p_halt;
    halt_wr |=> seq_state_o == 3'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop the sequencer");
  property p_fsk;
    !fsk_mode_i |=> seq_state_o == 3'h0;
  endproperty
  a_fsk: assert property (p_fsk) else $error("sequencer active outside fsk");
  property p_idle_pwr;
    seq_state_o == 3'h1 && $past(seq_state_o) == 3'h5 && $past(quiet)
      |-> mode_cmd_o == (cfg_reg[5] ? 3'h0 : 3'h1);
  endproperty
  a_idle_pwr: assert property (p_idle_pwr) else $error("wrong idle mode");
  property p_idle_exit;
    seq_state_o == 3'h1 && timer_one_event_o && quiet
      |=> seq_state_o == (cfg_reg[1] ? 3'h3 : 3'h2);
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("wrong idle exit");
  property p_idle_hold;
    seq_state_o == 3'h1 && !timer_one_event_o && quiet |=> seq_state_o == 3'h1;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left early");
  property p_tx_exit;
    seq_state_o == 3'h2 && frame_sent_event_i && quiet
      |=> seq_state_o == (cfg_reg[0] ? 3'h3 : 3'h5);
  endproperty
  a_tx_exit: assert property (p_tx_exit) else $error("wrong transmit exit");
  property p_modes;
    (seq_state_o == 3'h2 |-> mode_cmd_o == 3'h3) and
    (seq_state_o == 3'h3 && $past(seq_state_o) == 3'h3 |-> mode_cmd_o == 3'h4);
  endproperty
  a_modes: assert property (p_modes) else $error("wrong mode command");
  property p_rx_t2;
    seq_state_o == 3'h3 && timer_two_event_o && quiet |=> seq_state_o == 3'h5;
  endproperty
  a_rx_t2: assert property (p_rx_t2) else $error("timer two ignored");
  property p_lpsel;
    seq_state_o == 3'h5 && quiet |=> seq_state_o == (cfg_reg[2] ? 3'h1 : 3'h0);
  endproperty
  a_lpsel: assert property (p_lpsel) else $error("wrong low power choice");
  property p_relaunch;
    receiver_relaunch_o |-> seq_state_o == 3'h3 && $past(seq_state_o) == 3'h6;
  endproperty
  a_relaunch: assert property (p_relaunch) else $error("bad relaunch");
  c_idle_exit: cover property (seq_state_o == 3'h1 && timer_one_event_o);
  c_relaunch: cover property (receiver_relaunch_o);
  c_rx_t2: cover property (seq_state_o == 3'h3 && timer_two_event_o);
endmodule // rmsq_sequencer_sva

// ### verification/rmsq_radio_model.sv
module rmsq_radio_model (
  input wire sys_clk_i,
  input wire rst_i,
  input wire set_i,
  input wire [2:0] set_mode_i,
  input wire [2:0] mode_cmd_i,
  input wire cmd_valid_i,
  output reg [2:0] chip_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Chip follows each command at once; settling delays are not modelled
  always @(posedge sys_clk_i) begin
    if (rst_i) chip_mode_o <= 3'h1;
    else if (set_i) chip_mode_o <= set_mode_i;
    else if (cmd_valid_i) chip_mode_o <= mode_cmd_i;
  end
endmodule // rmsq_radio_model

// ### verification/radio_mode_sequencer_fsm_tb_top.sv
module radio_mode_sequencer_fsm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg fsk = 1'b1;
  reg [10:0] ev = 11'h000;
  reg set_s = 1'b0;
  reg [2:0] set_m = 3'h1;
  reg crc_en = 1'b1;
  reg flush = 1'b0;
  reg [15:0] gap = 16'h0000;
  integer c0 = 0;
  wire [15:0] rdata;
  wire [2:0] mcmd;
  wire [2:0] st;
  wire [2:0] chip;
  wire mval, rl, t1, t2;
  integer fail_count = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer rl_cnt = 0;
  integer k;
  rmsq_sequencer u_dut (.sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .fsk_mode_i(fsk),
    .chip_mode_i(chip), .crc_enable_i(crc_en), .bad_check_auto_flush_i(flush),
    .frame_sent_event_i(ev[0]), .payload_ready_event_i(ev[1]), .check_good_event_i(ev[2]),
    .level_event_i(ev[3]), .sync_match_event_i(ev[4]), .preamble_seen_event_i(ev[5]),
    .queue_level_event_i(ev[6]), .queue_drained_event_i(ev[7]),
    .level_wait_timeout_i(ev[8]), .preamble_wait_timeout_i(ev[9]),
    .sync_wait_timeout_i(ev[10]), .mode_cmd_o(mcmd), .mode_cmd_valid_o(mval),
    .receiver_relaunch_o(rl), .timer_one_event_o(t1), .timer_two_event_o(t2),
    .seq_state_o(st));
  rmsq_radio_model u_radio (.sys_clk_i(clk), .rst_i(rst), .set_i(set_s), .set_mode_i(set_m),
    .mode_cmd_i(mcmd), .cmd_valid_i(mval), .chip_mode_o(chip));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Watchdog well above the longest timer walk
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rl) rl_cnt <= rl_cnt + 1;
    if (cyc == 60000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask
  task pulse(input integer i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 11'h000;
  endtask
  task set_chip(input [2:0] m);
    @(posedge clk);
    set_s <= 1'b1;
    set_m <= m;
    @(posedge clk);
    set_s <= 1'b0;
  endtask
  // Launch never carries halt in the same write
  task launch(input [5:0] lo);
    wr(8'h00, {8'h00, 2'h2, lo});
  endtask
  // Halt leaves the chip where it was; park it in Standby so the next launch is legal
  task halt;
    wr(8'h00, 16'h0040);
    set_chip(3'h1);
  endtask
  // Mode code 7 means the mode is not judged
  task expect_st(input [2:0] s, input [2:0] m);
    repeat (3) @(posedge clk);
    #1;
    cmp({13'h0000, st}, {13'h0000, s});
    if (m != 3'h7) cmp({13'h0000, mcmd}, {13'h0000, m});
  endtask
  task to_case(input [1:0] c, input integer e, input [2:0] s, input [2:0] m);
    wr(8'h01, {8'h00, 3'h3, c, 3'h0});
    launch(6'h08);
    pulse(e);
    expect_st(s, m);
    halt;
  endtask
  task pd_case(input [2:0] c, input [2:0] s, input [2:0] m);
    wr(8'h01, {8'h00, 3'h1, 2'h0, c});
    launch(6'h08);
    pulse(1);
    pulse(7);
    expect_st(s, m);
    halt;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 5; k = k + 1) rd(k[7:0], 16'h0000);
    rd(8'h10, 16'h0000);
    // Receive, payload to low power, back to sleep
    set_chip(3'h0);
    wr(8'h01, 16'h0040);
    launch(6'h08);
    expect_st(3'h3, 3'h4);
    rd(8'h04, 16'h0013);
    pulse(1);
    expect_st(3'h0, 3'h0);
    // Launch while the chip transmits is ignored
    set_chip(3'h3);
    launch(6'h11);
    expect_st(3'h0, 3'h0);
    // Transmit exits and halt
    set_chip(3'h1);
    launch(6'h11);
    expect_st(3'h2, 3'h3);
    pulse(0);
    expect_st(3'h3, 3'h4);
    halt;
    expect_st(3'h0, 3'h7);
    launch(6'h10);
    pulse(0);
    expect_st(3'h0, 3'h1);
    launch(6'h18);
    expect_st(3'h7, 3'h7);
    pulse(6);
    expect_st(3'h2, 3'h3);
    halt;
    launch(6'h04);
    expect_st(3'h1, 3'h1);
    halt;
    // Each wait timeout restarts the receiver
    wr(8'h01, 16'h0060);
    launch(6'h08);
    for (k = 8; k < 11; k = k + 1) pulse(k);
    expect_st(3'h3, 3'h4);
    pulse(1);
    expect_st(3'h3, 3'h4);
    cmp(rl_cnt[15:0], 16'h0004);
    // Bad payload is no timeout with auto flush on or check off
    @(posedge clk);
    flush <= 1'b1;
    pulse(1);
    @(posedge clk);
    flush <= 1'b0;
    crc_en <= 1'b0;
    pulse(1);
    expect_st(3'h3, 3'h4);
    cmp(rl_cnt[15:0], 16'h0004);
    @(posedge clk);
    crc_en <= 1'b1;
    halt;
    to_case(2'h1, 9, 3'h2, 3'h3);
    to_case(2'h2, 10, 3'h0, 3'h1);
    to_case(2'h3, 8, 3'h0, 3'h7);
    pd_case(3'h0, 3'h0, 3'h7);
    pd_case(3'h1, 3'h2, 3'h3);
    pd_case(3'h2, 3'h0, 3'h1);
    pd_case(3'h3, 3'h3, 3'h4);
    pd_case(3'h4, 3'h3, 3'h4);
    // Good check reaches packet received and the receiver stays on
    wr(8'h01, 16'h0061);
    launch(6'h08);
    pulse(2);
    expect_st(3'h4, 3'h4);
    halt;
    // Event exits to off
    for (k = 4; k < 7; k = k + 1) begin
      wr(8'h01, {8'h00, k[2:0], 5'h00});
      launch(6'h08);
      pulse(k - 1);
      expect_st(3'h0, 3'h4);
      halt;
    end
    // Unused codes ignore events; fsk loss stops all
    wr(8'h01, 16'h0000);
    launch(6'h08);
    for (k = 0; k < 6; k = k + 1) pulse(k);
    wr(8'h01, 16'h00E0);
    for (k = 0; k < 6; k = k + 1) pulse(k);
    expect_st(3'h3, 3'h4);
    @(posedge clk);
    fsk <= 1'b0;
    expect_st(3'h0, 3'h7);
    @(posedge clk);
    fsk <= 1'b1;
    set_chip(3'h1);
    // Timers: receive, timer two to idle, timer one to transmit
    wr(8'h02, 16'h0101);
    wr(8'h03, 16'h0101);
    wr(8'h01, 16'h0000);
    launch(6'h2C);
    expect_st(3'h3, 3'h4);
    @(posedge t1);
    #1;
    c0 = cyc;
    @(posedge t2);
    #1;
    gap = cyc[15:0] - c0[15:0];
    cmp(gap, 16'h3200);
    expect_st(3'h1, 3'h0);
    @(posedge t1);
    expect_st(3'h2, 3'h3);
    halt;
    report_and_stop;
  end
endmodule // radio_mode_sequencer_fsm_tb_top
bind rmsq_sequencer rmsq_sequencer_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .fsk_mode_i(fsk_mode_i), .frame_sent_event_i(frame_sent_event_i), .mode_cmd_o(mode_cmd_o),
  .receiver_relaunch_o(receiver_relaunch_o), .timer_one_event_o(timer_one_event_o),
  .timer_two_event_o(timer_two_event_o), .seq_state_o(seq_state_o));
